// *** verilog/mps_sync.sv ***
// Shared constants for the power on/off sequencer
package mps_pkg;

  // Clock and millisecond timebase
  localparam int unsigned CLK_PERIOD_PS = 4000;                      // 250 MHz
  localparam int unsigned PS_PER_MS     = 1000000000;                // Picoseconds in 1 ms
  localparam int unsigned CYC_PER_MS    = PS_PER_MS / CLK_PERIOD_PS; // Cycles per ms tick

  // Millisecond counter width
  localparam int unsigned MS_W = 16;

  // Timing figures, all in milliseconds
  localparam logic [15:0] T_RESET_END_MS  = 16'h0064; // 100 ms reset phase
  localparam logic [15:0] T_HWINIT_END_MS = 16'h1388; // 5 s hardware init
  localparam logic [15:0] T_ACTIVE_MS     = 16'h8CA0; // 36 s to system active
  localparam logic [15:0] T_OFF_HOLD_MS   = 16'h0834; // 2.1 s ignition hold for off
  localparam logic [15:0] T_RTC_HOLD_MS   = 16'h07D0; // 2000 ms emergency RTC limit
  localparam logic [15:0] T_PD_MAX_MS     = 16'h07D0; // 2000 ms time_to_powered_down
  localparam logic [15:0] T_SHUTDOWN_MS   = 16'h4E20; // 20 s complete power-down
  localparam logic [15:0] T_LIVE_HALF_MS  = 16'h1388; // 5 s half period, 0.1 Hz
  localparam logic [15:0] T_RESTART_MS    = 16'h0064; // 100 ms ignition after release
  localparam logic [15:0] T_SAVE_MS       = 16'h0BB8; // Log-off and data save time
  localparam logic [15:0] T_PD_MS         = 16'h01F4; // Emergency power-down time

  // Sequencer states
  typedef enum logic [3:0] {
    ST_OFF       = 4'h0,
    ST_RESET_PH  = 4'h1,
    ST_HW_INIT   = 4'h2,
    ST_FW_INIT   = 4'h3,
    ST_ACTIVE    = 4'h4,
    ST_SAVE      = 4'h5,
    ST_DOWN_WAIT = 4'h6,
    ST_EMERG     = 4'h7,
    ST_RESTART   = 4'h8
  } mps_state_e;

endpackage

`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Pin input conditioner: four flops, change accepted when stages two and three agree
module mps_sync #(
  parameter logic RESET_VAL = 1'b1  // Idle level of the pin
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Pin and conditioned level
  input  wire logic pin,
  output logic      level
);

  logic s1;          // First stage, read only by s2
  logic s2;          // Second stage
  logic s3;          // Third stage
  logic next_level;  // Accepted level

  // Accept a change only once the two late stages agree
  always_comb begin
    next_level = (s2 == s3) ? s3 : level;
  end

  // Register the chain
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1    <= RESET_VAL;
      s2    <= RESET_VAL;
      s3    <= RESET_VAL;
      level <= RESET_VAL;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end

endmodule

// *** verilog/mps_sequencer.sv ***
// Notes on behaviour
// RQ1 - Ignition low while off starts power-on
// RQ2 - Host holds ignition low 100 ms
// RQ3 - On/off mode: 2.1 s hold, off after release
// RQ4 - Ignition off runs same orderly shutdown
// RQ5 - Two ignition modes, on/off off by default
// RQ6 - Host waits 36 s before switch-off
// RQ7 - Emergency off only after 5 s hang
// RQ8 - Host holds emergency low until indicator high
// RQ9 - Emergency line pulled up inside, open-drain host
// RQ10 - Ignition released first: module stays off
// RQ11 - Ignition low 100 ms after: module restarts
// RQ12 - Emergency power-down within 2000 ms
// RQ13 - Emergency held over 2000 ms resets RTC
// RQ14 - Command answered OK after save, down 20 s
// RQ15 - Power indicator high while switching off
// RQ16 - Host keeps supply until external supply low
// RQ17 - Host waits 1 s after supply low
// RQ18 - Host drives no current while powered down
// RQ19 - Four startup phases, active after 36 s
// RQ20 - Liveness toggles at 0.1 Hz from firmware init
// RQ21 - Host synchronises inputs, times with counters
`timescale 1ns/1ps

module mps_sequencer #(
  parameter int unsigned CYC_PER_MS = mps_pkg::CYC_PER_MS  // Shorten for simulation
) (
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       NRST,
  // Host control pins, open-drain, active low
  input  wire logic       IGNITION_LINE_N,
  input  wire logic       EMERGENCY_OFF_LINE_N,
  // Configuration and command
  input  wire logic       ONOFF_MODE,
  input  wire logic       SHUTDOWN_COMMAND,
  // Status outputs
  output logic            SHUTDOWN_OK,
  output logic            RTC_RESET,
  output logic            POWER_INDICATOR,
  output logic            EXTERNAL_SUPPLY_OUTPUT,
  output logic            LIVENESS_OUTPUT,
  output logic            IF_INITIAL,
  output logic            PULLUP_ENABLE,
  output logic [3:0]      SEQ_STATE
);

  localparam int unsigned MS_W = mps_pkg::MS_W;
  localparam logic [MS_W-1:0] MS_MAX = {MS_W{1'b1}};

  ////////////////////////////////////////////////////////////////////////////////
  // Pin conditioning

  logic ign_s;   // Conditioned ignition level
  logic em_s;    // Conditioned emergency level
  logic ign_low; // Ignition asserted
  logic em_low;  // Emergency asserted

  mps_sync #(.RESET_VAL(1'b1)) u_ign_sync (
    .clk   (CLOCK),
    .nrst  (NRST),
    .pin   (IGNITION_LINE_N),
    .level (ign_s)
  );

  mps_sync #(.RESET_VAL(1'b1)) u_em_sync (
    .clk   (CLOCK),
    .nrst  (NRST),
    .pin   (EMERGENCY_OFF_LINE_N),
    .level (em_s)
  );

  assign ign_low = ~ign_s;
  assign em_low  = ~em_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond timebase

  logic [31:0] pre_cnt;       // Cycle prescaler
  logic [31:0] next_pre_cnt;
  logic        ms_tick;       // One-cycle pulse each millisecond
  logic        next_ms_tick;

  // Divide the clock down; all long waits count ms, keeping counters narrow
  always_comb begin
    next_ms_tick = 1'b0;
    next_pre_cnt = pre_cnt + 32'h00000001;
    if (pre_cnt >= CYC_PER_MS - 1) begin
      next_pre_cnt = 32'h00000000;
      next_ms_tick = 1'b1;
    end
  end

  // Register the prescaler
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pre_cnt <= 32'h00000000;
      ms_tick <= 1'b0;
    end else begin
      pre_cnt <= next_pre_cnt;
      ms_tick <= next_ms_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Hold-time counters for both host lines

  logic [MS_W-1:0] igt_hold;       // Ms the ignition has been low
  logic [MS_W-1:0] next_igt_hold;
  logic [MS_W-1:0] em_hold;        // Ms the emergency line has been low
  logic [MS_W-1:0] next_em_hold;

  // Saturating counts; cleared as soon as the line is released
  always_comb begin
    next_igt_hold = igt_hold;
    next_em_hold  = em_hold;
    if (!ign_low) begin
      next_igt_hold = '0;
    end else if (ms_tick && igt_hold != MS_MAX) begin
      next_igt_hold = igt_hold + 1'b1;
    end
    if (!em_low) begin
      next_em_hold = '0;
    end else if (ms_tick && em_hold != MS_MAX) begin
      next_em_hold = em_hold + 1'b1;
    end
  end

  // Register the hold counters
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      igt_hold <= '0;
      em_hold  <= '0;
    end else begin
      igt_hold <= next_igt_hold;
      em_hold  <= next_em_hold;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  mps_pkg::mps_state_e state;       // Current phase
  mps_pkg::mps_state_e next_state;
  logic [MS_W-1:0] ms_cnt;          // Ms since ignition or since shutdown start
  logic [MS_W-1:0] next_ms_cnt;
  logic [MS_W-1:0] live_cnt;        // Ms since last liveness edge
  logic [MS_W-1:0] next_live_cnt;
  logic            rtc_done;        // RTC reset already issued this emergency
  logic            next_rtc_done;
  logic            next_ok;
  logic            next_rtc;
  logic            next_pwr;
  logic            next_ext;
  logic            next_live;
  logic            next_ifinit;
  logic            running;         // Any powered operating phase
  logic            ign_off_req;     // Ignition switch-off completed

  assign running = (state == mps_pkg::ST_HW_INIT) || (state == mps_pkg::ST_FW_INIT) ||
                   (state == mps_pkg::ST_ACTIVE);
  // Switch-off counts only at release after a long enough hold
  assign ign_off_req = ONOFF_MODE && ign_s && (igt_hold >= mps_pkg::T_OFF_HOLD_MS); // RQ3 RQ5

  // Next-state and output logic
  always_comb begin
    next_state    = state;
    next_ms_cnt   = (ms_tick && ms_cnt != MS_MAX) ? ms_cnt + 1'b1 : ms_cnt;
    next_live_cnt = live_cnt;
    next_rtc_done = rtc_done;
    next_ok       = 1'b0;
    next_rtc      = 1'b0;
    next_pwr      = POWER_INDICATOR;
    next_ext      = EXTERNAL_SUPPLY_OUTPUT;
    next_live     = LIVENESS_OUTPUT;
    next_ifinit   = IF_INITIAL;
    // Emergency wins over every other request while powered
    if (em_low && (running || state == mps_pkg::ST_RESET_PH ||
                   state == mps_pkg::ST_SAVE || state == mps_pkg::ST_DOWN_WAIT)) begin
      next_state    = mps_pkg::ST_EMERG;
      next_ms_cnt   = '0;
      next_rtc_done = 1'b0;
    end else begin
      unique case (state)
        // Powered down: indicator high, supply off
        mps_pkg::ST_OFF: begin
          if (ign_low) begin
            next_state  = mps_pkg::ST_RESET_PH; // RQ1
            next_ms_cnt = '0;
          end
        end
        // Reset phase: outputs still in off levels
        mps_pkg::ST_RESET_PH: begin
          if (ms_cnt >= mps_pkg::T_RESET_END_MS) begin
            next_state = mps_pkg::ST_HW_INIT; // RQ19
            next_pwr   = 1'b0;
            next_ext   = 1'b1;
          end
        end
        // Hardware init until 5 s
        mps_pkg::ST_HW_INIT: begin
          if (ms_cnt >= mps_pkg::T_HWINIT_END_MS) begin
            next_state    = mps_pkg::ST_FW_INIT; // RQ19
            next_live     = 1'b1;               // RQ20
            next_live_cnt = '0;
          end
        end
        // Firmware init until 36 s, then interfaces leave initial states
        mps_pkg::ST_FW_INIT: begin
          if (ms_cnt >= mps_pkg::T_ACTIVE_MS) begin
            next_state  = mps_pkg::ST_ACTIVE; // RQ19
            next_ifinit = 1'b0;
          end
        end
        // Running normally
        mps_pkg::ST_ACTIVE: begin
          next_state = state;
        end
        // Log-off and data save; OK only once saved
        mps_pkg::ST_SAVE: begin
          if (ms_cnt >= mps_pkg::T_SAVE_MS) begin
            next_state = mps_pkg::ST_DOWN_WAIT;
            next_ok    = 1'b1; // RQ14
          end
        end
        // Remainder of the 20 s power-down, then supply off
        mps_pkg::ST_DOWN_WAIT: begin
          if (ms_cnt >= mps_pkg::T_SHUTDOWN_MS) begin
            next_state = mps_pkg::ST_OFF; // RQ14
            next_ext   = 1'b0;
          end
        end
        // Emergency: power down, then follow the ignition at release
        mps_pkg::ST_EMERG: begin
          if (ms_cnt >= mps_pkg::T_PD_MS) begin
            next_pwr  = 1'b1; // RQ12
            next_ext  = 1'b0;
            next_live = 1'b0;
          end
          if (em_hold > mps_pkg::T_RTC_HOLD_MS && !rtc_done) begin
            next_rtc      = 1'b1; // RQ13
            next_rtc_done = 1'b1;
          end
          if (!em_low) begin
            // Early release still forces powered-down levels
            next_pwr    = 1'b1;
            next_ext    = 1'b0;
            next_live   = 1'b0;
            next_ms_cnt = '0;
            next_state  = ign_low ? mps_pkg::ST_RESTART : mps_pkg::ST_OFF; // RQ10 RQ11
          end
        end
        // Ignition must stay low 100 ms after release to restart
        mps_pkg::ST_RESTART: begin
          if (!ign_low) begin
            next_state = mps_pkg::ST_OFF; // RQ11
          end else if (ms_cnt >= mps_pkg::T_RESTART_MS) begin
            next_state  = mps_pkg::ST_RESET_PH; // RQ11
            next_ms_cnt = '0;
          end
        end
        default: begin
          next_state = mps_pkg::ST_OFF;
        end
      endcase
      // Command or ignition switch-off share the orderly shutdown
      if (running && (SHUTDOWN_COMMAND || ign_off_req)) begin
        next_state  = mps_pkg::ST_SAVE; // RQ4
        next_ms_cnt = '0;
        next_pwr    = 1'b1;             // RQ15
      end
    end
    // Liveness toggles every 5 s once firmware runs, low otherwise
    if (next_state == mps_pkg::ST_FW_INIT || next_state == mps_pkg::ST_ACTIVE) begin
      if (state == mps_pkg::ST_FW_INIT || state == mps_pkg::ST_ACTIVE) begin
        if (ms_tick) begin
          next_live_cnt = live_cnt + 1'b1;
          if (live_cnt + 1'b1 >= mps_pkg::T_LIVE_HALF_MS) begin
            next_live     = ~LIVENESS_OUTPUT; // RQ20
            next_live_cnt = '0;
          end
        end
      end
    end else begin
      next_live = 1'b0;
    end
    // Interfaces are in initial state outside system active
    if (next_state != mps_pkg::ST_ACTIVE) begin
      next_ifinit = 1'b1; // RQ19
    end
  end

  // Register sequencer state and all top-level outputs
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state                  <= mps_pkg::ST_OFF;
      ms_cnt                 <= '0;
      live_cnt               <= '0;
      rtc_done               <= 1'b0;
      SHUTDOWN_OK            <= 1'b0;
      RTC_RESET              <= 1'b0;
      POWER_INDICATOR        <= 1'b1;
      EXTERNAL_SUPPLY_OUTPUT <= 1'b0;
      LIVENESS_OUTPUT        <= 1'b0;
      IF_INITIAL             <= 1'b1;
      PULLUP_ENABLE          <= 1'b0;
      SEQ_STATE              <= 4'h0;
    end else begin
      state                  <= next_state;
      ms_cnt                 <= next_ms_cnt;
      live_cnt               <= next_live_cnt;
      rtc_done               <= next_rtc_done;
      SHUTDOWN_OK            <= next_ok;
      RTC_RESET              <= next_rtc;
      POWER_INDICATOR        <= next_pwr;
      EXTERNAL_SUPPLY_OUTPUT <= next_ext;
      LIVENESS_OUTPUT        <= next_live;
      IF_INITIAL             <= next_ifinit;
      PULLUP_ENABLE          <= 1'b1; // RQ9
      SEQ_STATE              <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  AST_POWER_ON: assert property ( // RQ1
    state == mps_pkg::ST_OFF && ign_low |=> state == mps_pkg::ST_RESET_PH)
    else $error("ignition low while off did not start power-on");

  AST_HW_PHASE: assert property ( // RQ19
    $rose(EXTERNAL_SUPPLY_OUTPUT) |-> state == mps_pkg::ST_HW_INIT &&
      ms_cnt >= mps_pkg::T_RESET_END_MS)
    else $error("external supply rose outside hardware init");

  AST_ACTIVE_TIME: assert property ( // RQ19
    state == mps_pkg::ST_ACTIVE && $past(state) == mps_pkg::ST_FW_INIT |->
      ms_cnt >= mps_pkg::T_ACTIVE_MS && !IF_INITIAL)
    else $error("system active entered too early");

  AST_MODE_GATE: assert property ( // RQ5
    running && !ONOFF_MODE && !SHUTDOWN_COMMAND && !em_low |=>
      state != mps_pkg::ST_SAVE)
    else $error("ignition switch-off taken in on-only mode");

  AST_IGN_OFF: assert property ( // RQ3
    running && ONOFF_MODE && ign_s && igt_hold >= mps_pkg::T_OFF_HOLD_MS && !em_low |=>
      state == mps_pkg::ST_SAVE && POWER_INDICATOR)
    else $error("ignition release after long hold did not shut down");

  AST_IND_OFF: assert property ( // RQ15
    state == mps_pkg::ST_SAVE || state == mps_pkg::ST_DOWN_WAIT |-> POWER_INDICATOR)
    else $error("power indicator low while switching off");

  AST_OK_TIME: assert property ( // RQ14
    SHUTDOWN_OK |-> state == mps_pkg::ST_DOWN_WAIT && ms_cnt >= mps_pkg::T_SAVE_MS)
    else $error("OK answered before data saved");

  AST_RTC: assert property ( // RQ13
    RTC_RESET |-> $past(state) == mps_pkg::ST_EMERG &&
      $past(em_hold) > mps_pkg::T_RTC_HOLD_MS)
    else $error("RTC reset without long emergency pulse");

  AST_PD_BOUND: assert property ( // RQ12
    state == mps_pkg::ST_EMERG && ms_cnt > mps_pkg::T_PD_MS |->
      POWER_INDICATOR && !EXTERNAL_SUPPLY_OUTPUT)
    else $error("emergency power-down not reached in time");

  AST_STAY_OFF: assert property ( // RQ10
    state == mps_pkg::ST_EMERG && em_s && ign_s |=> state == mps_pkg::ST_OFF)
    else $error("module did not stay off after emergency release");

  COV_START: cover property (state == mps_pkg::ST_FW_INIT ##1 state == mps_pkg::ST_ACTIVE);
  COV_CMD_OFF: cover property (SHUTDOWN_OK);
  COV_RESTART: cover property (state == mps_pkg::ST_RESTART ##1 state == mps_pkg::ST_RESET_PH);

endmodule

// *** dv/mps_host_model.sv ***
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Host controller: open-drain drivers on the two control lines, status syncs
module mps_host_model #(
  parameter int unsigned CYC_PER_MS = 1  // Timebase, cycles per ms
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Requests from the bench, high = pull line low
  input  wire logic ign_req,
  input  wire logic emg_req,
  // Device status
  input  wire logic power_indicator,
  input  wire logic external_supply_output,
  input  wire logic pullup_enable,
  // Resolved line levels
  output logic      ignition_line_n,
  output logic      emergency_off_line_n,
  // Synchronised status
  output logic      ind_sync,
  output logic      sup_sync
);
  logic        ign_oe_n;   // Low while the ignition line is pulled low
  logic        emg_oe_n;   // Low while the emergency line is pulled low
  logic [1:0]  ind_ff;     // Indicator synchroniser
  logic [1:0]  sup_ff;     // Supply synchroniser
  int unsigned ign_cnt;    // Ignition hold time in cycles
  logic        float_bit;  // Stands in for an unpowered pull-up

  assign ind_sync = ind_ff[1];
  assign sup_sync = sup_ff[1];

  // Host drives only low; a released line is left to the pull-up.
  // Without the pull-up the wire floats, so it is shown toggling.
  assign ignition_line_n      = !ign_oe_n ? 1'b0 : (pullup_enable ? 1'b1 : float_bit);
  assign emergency_off_line_n = !emg_oe_n ? 1'b0 : (pullup_enable ? 1'b1 : float_bit);

  // Hold timers and status synchronisers on the host clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ign_oe_n  <= 1'b1;
      emg_oe_n  <= 1'b1;
      ind_ff    <= 2'h3;
      sup_ff    <= 2'h0;
      ign_cnt   <= 0;
      float_bit <= 1'b1;
    end else begin
      ind_ff    <= {ind_ff[0], power_indicator};
      sup_ff    <= {sup_ff[0], external_supply_output};
      float_bit <= ~float_bit;
      ign_cnt   <= !ign_oe_n ? ign_cnt + 1 : 0;
      // Short requests are stretched to the minimum ignition hold
      if (ign_req) begin
        ign_oe_n <= 1'b0;
      end else if (ign_cnt >= 100 * CYC_PER_MS) begin
        ign_oe_n <= 1'b1;
      end
      // Emergency stays pulled until the device shows powered down
      if (emg_req) begin
        emg_oe_n <= 1'b0;
      end else if (ind_sync) begin
        emg_oe_n <= 1'b1;
      end
    end
  end
endmodule

// *** dv/mps_sequencer_tb_top.sv ***
`timescale 1ns/1ps

module mps_sequencer_tb_top;
  // One ms per cycle keeps the whole run near 100k cycles
  localparam int MS   = 1;
  localparam int TOL  = 8;
  localparam int P_HW = int'(mps_pkg::T_RESET_END_MS) * MS;
  localparam int P_FW = int'(mps_pkg::T_HWINIT_END_MS) * MS;
  localparam int P_AC = int'(mps_pkg::T_ACTIVE_MS) * MS;
  localparam int P_LV = int'(mps_pkg::T_LIVE_HALF_MS) * MS;
  localparam int P_SV = int'(mps_pkg::T_SAVE_MS) * MS;
  localparam int P_PD = int'(mps_pkg::T_PD_MS) * MS;
  localparam int P_RT = int'(mps_pkg::T_RTC_HOLD_MS) * MS;
  localparam int P_RS = int'(mps_pkg::T_RESTART_MS) * MS;
  localparam int P_SD = int'(mps_pkg::T_SHUTDOWN_MS) * MS;
  localparam int P_OF = int'(mps_pkg::T_OFF_HOLD_MS) * MS + 50;
  // Bit masks into the output view
  localparam logic [15:0] M_ST  = 16'h0F00;
  localparam logic [15:0] M_PI  = 16'h0080;
  localparam logic [15:0] M_SUP = 16'h0040;
  localparam logic [15:0] M_LV  = 16'h0020;
  localparam logic [15:0] M_IFI = 16'h0010;
  localparam logic [15:0] M_OK  = 16'h0008;
  localparam logic [15:0] M_RTC = 16'h0004;

  logic        CLOCK = 1'b0;
  logic        NRST;
  logic        ONOFF_MODE;
  logic        SHUTDOWN_COMMAND;
  logic        IGNITION_LINE_N;
  logic        EMERGENCY_OFF_LINE_N;
  logic        SHUTDOWN_OK;
  logic        RTC_RESET;
  logic        POWER_INDICATOR;
  logic        EXTERNAL_SUPPLY_OUTPUT;
  logic        LIVENESS_OUTPUT;
  logic        IF_INITIAL;
  logic        PULLUP_ENABLE;
  logic [3:0]  SEQ_STATE;
  logic        ign_req;
  logic        emg_req;
  logic        sup_sync;
  logic [15:0] view;
  int          now_cyc = 0;
  int          err_total = 0;
  int          cmp_count = 0;

  assign view = {4'h0, SEQ_STATE, POWER_INDICATOR, EXTERNAL_SUPPLY_OUTPUT, LIVENESS_OUTPUT,
                 IF_INITIAL, SHUTDOWN_OK, RTC_RESET, PULLUP_ENABLE, 1'b0};

  // Clock and cycle count
  always #2 CLOCK = ~CLOCK;
  always @(posedge CLOCK) now_cyc <= now_cyc + 1;

  mps_sequencer #(.CYC_PER_MS(MS)) mps_sequencer_inst (
    .CLOCK(CLOCK), .NRST(NRST), .IGNITION_LINE_N(IGNITION_LINE_N),
    .EMERGENCY_OFF_LINE_N(EMERGENCY_OFF_LINE_N), .ONOFF_MODE(ONOFF_MODE),
    .SHUTDOWN_COMMAND(SHUTDOWN_COMMAND), .SHUTDOWN_OK(SHUTDOWN_OK), .RTC_RESET(RTC_RESET),
    .POWER_INDICATOR(POWER_INDICATOR), .EXTERNAL_SUPPLY_OUTPUT(EXTERNAL_SUPPLY_OUTPUT),
    .LIVENESS_OUTPUT(LIVENESS_OUTPUT), .IF_INITIAL(IF_INITIAL),
    .PULLUP_ENABLE(PULLUP_ENABLE), .SEQ_STATE(SEQ_STATE));

  mps_host_model #(.CYC_PER_MS(MS)) mps_host_model_inst (
    .clk(CLOCK), .nrst(NRST), .ign_req(ign_req), .emg_req(emg_req),
    .power_indicator(POWER_INDICATOR), .external_supply_output(EXTERNAL_SUPPLY_OUTPUT),
    .pullup_enable(PULLUP_ENABLE), .ignition_line_n(IGNITION_LINE_N),
    .emergency_off_line_n(EMERGENCY_OFF_LINE_N), .ind_sync(), .sup_sync(sup_sync));

  ////////////////////////////////////////////////////////////////////////////////
  // Report and compare helpers
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] st(input mps_pkg::mps_state_e s);
    return {4'h0, s, 8'h00};
  endfunction

  // Bounded wait for a masked pattern; arrival must lie within TOL of cycle exp
  task automatic wait_on(input logic [15:0] mask, input logic [15:0] val, input int exp);
    while ((view & mask) !== val) begin
      if (now_cyc > exp + TOL) begin
        err_total++;
        $display("BAD t=%0t got=%0h exp=%0h", $time, view & mask, val);
        end_of_test();
      end
      @(posedge CLOCK);
      #1;
    end
    cmp_count++;
    if (now_cyc < exp - TOL) begin
      err_total++;
      $display("BAD t=%0t early cycle=%0h exp=%0h", $time, now_cyc, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic s_power_on();
    int t0;
    @(posedge CLOCK);
    ign_req <= 1'b1;
    t0 = now_cyc;
    @(posedge CLOCK);
    ign_req <= 1'b0;
    wait_on(M_ST, st(mps_pkg::ST_RESET_PH), t0 + 5);
    wait_on(M_ST, st(mps_pkg::ST_HW_INIT), t0 + P_HW);
    chk(view & (M_PI | M_SUP | M_IFI | M_LV), M_SUP | M_IFI);
    wait_on(M_ST, st(mps_pkg::ST_FW_INIT), t0 + P_FW);
    chk(view & (M_LV | M_IFI), M_LV | M_IFI);
    wait_on(M_LV, 16'h0000, t0 + P_FW + P_LV);
    wait_on(M_ST, st(mps_pkg::ST_ACTIVE), t0 + P_AC);
    chk(view & (M_IFI | M_PI), 16'h0000);
  endtask

  // On-only mode: a long ignition hold while running changes nothing
  task automatic s_onoff_off_ignored();
    @(posedge CLOCK);
    ign_req <= 1'b1;
    repeat (P_OF) @(posedge CLOCK);
    ign_req <= 1'b0;
    repeat (20) @(posedge CLOCK);
    #1;
    chk(view & M_ST, st(mps_pkg::ST_ACTIVE));
  endtask

  // Command off, then an emergency in the power-down wait ending in a restart
  task automatic s_cmd_then_emergency();
    int t1;
    @(posedge CLOCK);
    SHUTDOWN_COMMAND <= 1'b1;
    t1 = now_cyc;
    @(posedge CLOCK);
    SHUTDOWN_COMMAND <= 1'b0;
    wait_on(M_ST, st(mps_pkg::ST_SAVE), t1 + 1);
    chk(view & (M_PI | M_LV | M_IFI), M_PI | M_IFI);
    wait_on(M_OK, M_OK, t1 + P_SV);
    wait_on(M_ST, st(mps_pkg::ST_DOWN_WAIT), t1 + P_SV);
    // Ignition pulled with the emergency line and kept after it
    @(posedge CLOCK);
    emg_req <= 1'b1;
    ign_req <= 1'b1;
    t1 = now_cyc;
    wait_on(M_ST, st(mps_pkg::ST_EMERG), t1 + 5);
    wait_on(M_SUP, 16'h0000, t1 + P_PD);
    chk(view & M_PI, M_PI);
    wait_on(M_RTC, M_RTC, t1 + P_RT);
    @(posedge CLOCK);
    emg_req <= 1'b0;
    t1 = now_cyc;
    wait_on(M_ST, st(mps_pkg::ST_RESTART), t1 + 5);
    wait_on(M_ST, st(mps_pkg::ST_RESET_PH), t1 + P_RS);
    @(posedge CLOCK);
    t1 = now_cyc;
    ign_req <= 1'b0;
    wait_on(M_ST, st(mps_pkg::ST_ACTIVE), t1 + P_AC);
  endtask

  // On/off mode: off only after release, then the orderly shutdown
  task automatic s_ignition_off();
    int t2;
    @(posedge CLOCK);
    ONOFF_MODE <= 1'b1;
    ign_req    <= 1'b1;
    repeat (P_OF) @(posedge CLOCK);
    #1;
    chk(view & M_ST, st(mps_pkg::ST_ACTIVE));
    @(posedge CLOCK);
    ign_req <= 1'b0;
    t2 = now_cyc;
    wait_on(M_ST, st(mps_pkg::ST_SAVE), t2 + 5);
    chk(view & M_PI, M_PI);
    wait_on(M_OK, M_OK, t2 + P_SV);
    wait_on(M_ST | M_SUP, st(mps_pkg::ST_OFF), t2 + P_SD);
    chk(view & M_PI, M_PI);
  endtask

  // Restart 1 s after supply off; an emergency then ends off, or aborts a restart
  task automatic s_emerg_stay_off();
    int t3;
    repeat (1000 * MS) @(posedge CLOCK);
    chk({15'h0, sup_sync}, 16'h0000);
    ign_req <= 1'b1;
    t3 = now_cyc;
    @(posedge CLOCK);
    ign_req <= 1'b0;
    wait_on(M_ST, st(mps_pkg::ST_RESET_PH), t3 + 5);
    @(posedge CLOCK);
    emg_req <= 1'b1;
    t3 = now_cyc;
    wait_on(M_ST, st(mps_pkg::ST_EMERG), t3 + 5);
    repeat (P_PD + 2) @(posedge CLOCK);
    #1;
    chk(view & (M_PI | M_SUP | M_LV), M_PI);
    // Ignition already released: the module must stay off
    @(posedge CLOCK);
    emg_req <= 1'b0;
    t3 = now_cyc;
    wait_on(M_ST, st(mps_pkg::ST_OFF), t3 + 5);
    repeat (20) @(posedge CLOCK);
    #1;
    chk(view & M_ST, st(mps_pkg::ST_OFF));
    // Ignition raised before the restart delay ends: back to off
    @(posedge CLOCK);
    ign_req <= 1'b1;
    emg_req <= 1'b1;
    repeat (P_PD + 10) @(posedge CLOCK);
    emg_req <= 1'b0;
    t3 = now_cyc;
    wait_on(M_ST, st(mps_pkg::ST_RESTART), t3 + 5);
    @(posedge CLOCK);
    ign_req <= 1'b0;
    t3 = now_cyc;
    wait_on(M_ST, st(mps_pkg::ST_OFF), t3 + 5);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    NRST             = 1'b0;
    ONOFF_MODE       = 1'b0;
    SHUTDOWN_COMMAND = 1'b0;
    ign_req          = 1'b0;
    emg_req          = 1'b0;
    repeat (2) @(posedge CLOCK);
    #1;
    chk(view & 16'h0FFE, 16'h0090);  // RESET
    @(posedge CLOCK);
    NRST <= 1'b1;
    @(posedge CLOCK);
    #1;
    chk(view & 16'h0002, 16'h0002);  // RESET
    s_power_on();
    s_onoff_off_ignored();
    s_cmd_then_emergency();
    s_ignition_off();
    s_emerg_stay_off();
    end_of_test();
  end
endmodule
